// ### core/obc_pkg.sv
// Shared constants and carriers for the outbound command encoder.
// Assumes one 200 MHz core clock and a forwarded link clock made from it.
package obc_pkg;

    // Core clock and forwarded link clock periods
    localparam int CLK_PERIOD_NS = 5;
    localparam int LINK_PERIOD_NS = 125;
    // Core cycles per link cycle, rounded down as a longest time
    localparam int LINK_DIV = LINK_PERIOD_NS / CLK_PERIOD_NS;
    // Link cycles of all-zero idle before the nonzero idle starts
    localparam int RESET_SLOTS = 16;
    // Words in one outbound packet
    localparam int BEATS = 4;
    localparam int WORD_W = 15;

    // Outbound command codes
    localparam logic [4:0] CMD_IDLE_ZERO = 5'h00;
    localparam logic [4:0] CMD_PROBE_REPLY = 5'h01;
    localparam logic [4:0] CMD_NONZERO_IDLE = 5'h02;
    localparam logic [4:0] CMD_FLUSH_REQ = 5'h03;
    localparam logic [4:0] CMD_VICTIM_WB = 5'h04;
    localparam logic [4:0] CMD_CLEAN_NOTICE = 5'h05;
    localparam logic [4:0] CMD_DISCARD = 5'h06;
    localparam logic [4:0] CMD_BARRIER = 5'h07;
    localparam logic [4:0] CMD_IO_READ = 5'h08;
    localparam logic [4:0] CMD_IO_WRITE = 5'h0c;
    localparam logic [4:0] CMD_BLOCK_READ = 5'h10;
    localparam logic [4:0] CMD_EARLY_READ = 5'h14;
    localparam logic [4:0] CMD_READ_VIC = 5'h18;
    localparam logic [4:0] CMD_INV_UPG_VIC = 5'h1b;
    localparam logic [4:0] CMD_CLEAN_UPG = 5'h1c;
    localparam logic [4:0] CMD_SHARED_UPG = 5'h1d;
    localparam logic [4:0] CMD_COND_UPG = 5'h1e;
    localparam logic [4:0] CMD_INV_UPG = 5'h1f;

    // Read variants, also io mask grains 0..2
    localparam logic [1:0] RD_MODIFY = 2'h1;
    localparam logic [1:0] RD_UNCACHED = 2'h3;
    // Upgrade line states, index into the acknowledge control
    localparam logic [1:0] UPG_CLEAN = 2'h0;
    localparam logic [1:0] UPG_NONE = 2'h3;
    // Invalid-upgrade control bits
    localparam int INV_ON_BIT = 0;
    localparam int INV_BUS_BIT = 1;

    // Register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SENT = 8'h08;

    typedef enum logic [3:0] {
        OP_READ = 4'h0,
        OP_VICTIM_WB = 4'h1,
        OP_CLEAN_NOTICE = 4'h2,
        OP_DISCARD = 4'h3,
        OP_IO_READ = 4'h4,
        OP_IO_WRITE = 4'h5,
        OP_UPGRADE = 4'h6,
        OP_WRITE_HINT = 4'h7,
        OP_BARRIER = 4'h8
    } op_e;

    typedef enum logic [1:0] {
        PH_RESET = 2'b00,
        PH_IDLE = 2'b01,
        PH_SEND = 2'b10
    } phase_e;

    // One internal transaction, with its paired victim
    typedef struct packed {
        op_e op;
        logic [1:0] variant;
        logic condStore;
        logic hit;
        logic victimMade;
        logic withVictim;
        logic victimDirty;
        logic [2:0] id;
        logic [2:0] vicId;
        logic [7:0] mask;
        logic [39:0] addr;
        logic [39:0] vicAddr;
    } cmd_req_s;

    // Result of one probe lookup
    typedef struct packed {
        logic missed;
        logic [1:0] status;
        logic moveData;
        logic victimSent;
        logic [2:0] victimEntry;
        logic missSent;
        logic [2:0] missEntry;
    } probe_rep_s;

    // Software control word
    typedef struct packed {
        logic barrierNoticeEn;
        logic earlyReadEn;
        logic pairedVictimMode;
        logic cleanNoticeEn;
        logic discardEn;
        logic [1:0] invalidUpgradeCtrl;
        logic [2:0] upgradeAckCtrl;
        logic condStoreCmdEn;
    } ctrl_s;
    localparam int CTRL_W = $bits(ctrl_s);
    localparam ctrl_s CTRL_RESET = '0;

endpackage : obc_pkg

// ### core/link_clock_gen.sv
// Divider that makes the free-running forwarded link clock.
// Assumes the core clock; the slot tick marks each link cycle.
`timescale 1ns/1ps
module link_clock_gen
    import obc_pkg::*;
#(
    parameter int DIV = LINK_DIV
)(
    input wire logic ref_clk,
    input wire logic rst,
    output logic linkClk,
    output logic slotTick
);
    localparam int CW = $clog2(DIV + 1);

    // Divider state
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic clk;
        logic tick;
    } div_s;
    div_s st;
    div_s next_st;

    // Count core cycles, clock high in first half
    always_comb begin
        next_st = st;
        next_st.tick = (st.cnt == CW'(DIV - 1));
        next_st.cnt = next_st.tick ? '0 : st.cnt + 1'b1;
        next_st.clk = (next_st.cnt < CW'(DIV / 2));
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign linkClk = st.clk;
    assign slotTick = st.tick;
endmodule : link_clock_gen

// ### core/cmd_code_map.sv
// Maps one internal transaction onto an outbound command code.
// Assumes control settings are stable while a request is taken.
`timescale 1ns/1ps
module cmd_code_map
    import obc_pkg::*;
(
    input cmd_req_s req,
    input ctrl_s ctrl,
    output logic send,
    output logic [4:0] code,
    output logic rv,
    output logic follow,
    output logic [4:0] followCode
);
    // Block read family choice
    function automatic logic [4:0] readCode(input logic [1:0] v,
            input logic pair, input logic early);
        if (pair && v != RD_UNCACHED) begin
            readCode = CMD_READ_VIC | {3'b000, v};
        end else if (early) begin
            readCode = CMD_EARLY_READ | {3'b000, v};
        end else begin
            readCode = CMD_BLOCK_READ | {3'b000, v};
        end
    endfunction : readCode

    logic pair; // Victim travels with this request

    always_comb begin
        pair = req.withVictim && ctrl.pairedVictimMode;
        send = 1'b1;
        code = CMD_NONZERO_IDLE;
        rv = 1'b1;
        case (req.op)
            OP_READ: code = readCode(req.variant, pair, ctrl.earlyReadEn);
            OP_WRITE_HINT: begin
                if (!ctrl.invalidUpgradeCtrl[INV_ON_BIT]) begin
                    code = readCode(RD_MODIFY, pair, ctrl.earlyReadEn);
                end else if (!ctrl.invalidUpgradeCtrl[INV_BUS_BIT]) begin
                    send = 1'b0;
                end else begin
                    code = pair ? CMD_INV_UPG_VIC : CMD_INV_UPG;
                end
            end
            OP_UPGRADE: begin
                if (req.variant == UPG_NONE || !ctrl.upgradeAckCtrl[req.variant]) begin
                    send = 1'b0;
                end else if (req.condStore && ctrl.condStoreCmdEn) begin
                    code = CMD_COND_UPG;
                end else begin
                    code = (req.variant == UPG_CLEAN) ? CMD_CLEAN_UPG : CMD_SHARED_UPG;
                end
            end
            OP_VICTIM_WB: code = CMD_VICTIM_WB;
            OP_CLEAN_NOTICE: begin
                send = ctrl.cleanNoticeEn;
                code = CMD_CLEAN_NOTICE;
            end
            OP_DISCARD: begin
                send = ctrl.discardEn;
                code = CMD_DISCARD;
            end
            OP_IO_READ: begin
                send = (req.variant != UPG_NONE);
                code = CMD_IO_READ | {3'b000, req.variant};
            end
            OP_IO_WRITE: begin
                send = (req.variant != UPG_NONE);
                code = CMD_IO_WRITE | {3'b000, req.variant};
            end
            OP_BARRIER: begin
                send = ctrl.barrierNoticeEn;
                code = CMD_BARRIER;
            end
            default: send = 1'b0;
        endcase
        if (code[4:2] == CMD_EARLY_READ[4:2]) begin
            rv = !(req.hit || ctrl.pairedVictimMode || req.victimMade);
        end
        follow = send && pair && (req.victimDirty || ctrl.cleanNoticeEn)
            && (code[4:2] == CMD_READ_VIC[4:2] || req.op == OP_DISCARD);
        followCode = req.victimDirty ? CMD_VICTIM_WB : CMD_CLEAN_NOTICE;
    end
endmodule : cmd_code_map

// ### core/outbound_system_command_encoder.sv
// Framer for outbound commands on the 15-bit time-multiplexed bus.
// Assumes requesters on the core clock; the bus word steps once per
// forwarded link clock, which this block makes from its own clock.
//
// Overview of operation
// - Zero idle in reset, nonzero idle after
// - Probe reply uses code 00001
// - Flush request on victim index match
// - Barrier notice only while enabled
// - Block reads use codes 10000 to 10011
// - Early reads use codes 10100 to 10111
// - Victim-paired reads use 11000 to 11010
// - Writeback 00100, clean notice 00101, discard 00110
// - Clean, shared, conditional upgrades 11100 to 11110
// - Invalid upgrade 11111, with victim 11011
// - Early read valid bit cleared on hit
// - Victim packet immediately follows paired read
// - Discard followed atomically by its victim
// - Two-bit control selects write hint handling
// - Three-bit control selects upgrade acknowledges
// - Conditional store enable selects upgrade code
// - Four-cycle reply only for non-missed probes
// - Probe reply field layout over two words
// - Victim entry valid with move or sent
// - Status encodes clean, shared, dirty, shared dirty
// - Every command except the one-word idles spans four bus cycles
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
module outbound_system_command_encoder
    import obc_pkg::*;
#(
    parameter int RESET_SLOTS_P = RESET_SLOTS,
    parameter int DIV_P = LINK_DIV
)(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic cmdValid,
    input cmd_req_s cmdReq,
    output logic cmdReady,
    input wire logic probeValid,
    input probe_rep_s probeReply,
    output logic probeReady,
    input wire logic flushReq,
    output logic [WORD_W-1:0] outboundCmdBus,
    output logic linkClkOut
);
    // Packet of up to two commands, word 0 goes first
    typedef logic [2*BEATS-1:0][WORD_W-1:0] pkt_t;

    // Whole block state
    typedef struct packed {
        phase_e phase;
        pkt_t words;
        logic [3:0] left;
        logic [15:0] resetCnt;
        logic flushPend;
        ctrl_s ctrl;
        logic [31:0] rdata;
        logic [15:0] sentCnt;
        logic [WORD_W-1:0] bus;
        logic first;
    } st_s;

    st_s st; // Registered state
    st_s next_st; // Next state
    logic slotTick; // One core cycle per link cycle
    logic mapSend; // Mapped request goes out
    logic [4:0] mapCode; // Mapped command code
    logic mapRv; // Request valid bit
    logic mapFollow; // Victim packet follows
    logic [4:0] mapFollowCode; // Code of that victim packet
    logic idleSlot; // Free to start a packet
    pkt_t pkt; // Candidate packet

    // Lay one command onto four bus words
    function automatic logic [BEATS-1:0][WORD_W-1:0] buildPkt(
            input logic [4:0] code, input logic [7:0] mask,
            input logic [2:0] id, input logic rv, input logic [39:0] addr);
        logic [BEATS-1:0][WORD_W-1:0] w;
        w[0] = {1'b0, code, addr[39:31]};
        w[1] = addr[30:16];
        w[2] = {1'b0, mask, 1'b0, id, addr[15:14]};
        w[3] = {rv, addr[13:0]};
        buildPkt = w;
    endfunction : buildPkt

    // One-word idle slot
    function automatic logic [WORD_W-1:0] idleWord(input logic [4:0] code);
        idleWord = {1'b0, code, 9'h000};
    endfunction : idleWord

    // Codes that the bus may carry
    function automatic logic knownCode(input logic [4:0] c);
        case (c)
            CMD_IDLE_ZERO, CMD_PROBE_REPLY, CMD_NONZERO_IDLE,
            CMD_FLUSH_REQ, CMD_VICTIM_WB, CMD_CLEAN_NOTICE,
            CMD_DISCARD, CMD_BARRIER, CMD_INV_UPG_VIC,
            CMD_CLEAN_UPG, CMD_SHARED_UPG, CMD_COND_UPG,
            CMD_INV_UPG: knownCode = 1'b1;
            default: begin
                // Families with a two-bit variant
                knownCode = (c[4:2] == CMD_IO_READ[4:2] && c[1:0] != RD_UNCACHED)
                    || (c[4:2] == CMD_IO_WRITE[4:2] && c[1:0] != RD_UNCACHED)
                    || c[4:2] == CMD_BLOCK_READ[4:2]
                    || c[4:2] == CMD_EARLY_READ[4:2]
                    || c[4:2] == CMD_READ_VIC[4:2];
            end
        endcase
    endfunction : knownCode

    // Forwarded clock and slot pacing
    link_clock_gen #(
        .DIV(DIV_P)
    ) u_clk (
        .ref_clk(ref_clk),
        .rst(rst),
        .linkClk(linkClkOut),
        .slotTick(slotTick)
    );

    // Code selection for the waiting request
    cmd_code_map u_map (
        .req(cmdReq),
        .ctrl(st.ctrl),
        .send(mapSend),
        .code(mapCode),
        .rv(mapRv),
        .follow(mapFollow),
        .followCode(mapFollowCode)
    );

    // Probes win over flushes, flushes over commands
    assign idleSlot = slotTick && (st.phase == PH_IDLE);
    assign probeReady = idleSlot;
    assign cmdReady = idleSlot && !probeValid && !st.flushPend;

    // Build the candidate packet for the chosen source
    always_comb begin
        pkt = '0;
        if (probeValid) begin
            pkt[0] = {1'b0, CMD_PROBE_REPLY, probeReply.status,
                probeReply.moveData, probeReply.victimSent,
                probeReply.victimEntry, 2'b00};
            pkt[1] = {9'h000, probeReply.missSent, probeReply.missEntry, 2'b00};
        end else if (st.flushPend) begin
            pkt[BEATS-1:0] = buildPkt(CMD_FLUSH_REQ, 8'h00, 3'h0, 1'b1, 40'h0);
        end else begin
            pkt[BEATS-1:0] = buildPkt(mapCode, cmdReq.mask, cmdReq.id, mapRv,
                cmdReq.addr);
            pkt[2*BEATS-1:BEATS] = buildPkt(mapFollowCode, 8'h00, cmdReq.vicId,
                1'b1, cmdReq.vicAddr);
        end
    end

    // Next-state logic for framer and registers
    always_comb begin
        next_st = st;
        next_st.first = 1'b0;
        next_st.rdata = '0;
        // Register writes steer the framer
        if (regWr && regAddr == REG_CTRL) begin
            next_st.ctrl = ctrl_s'(regWdata[CTRL_W-1:0]);
        end
        // Register reads answer next cycle
        if (regRd) begin
            case (regAddr)
                REG_CTRL: next_st.rdata = 32'(st.ctrl);
                REG_STATUS: next_st.rdata = 32'({st.flushPend, st.phase});
                REG_SENT: next_st.rdata = 32'(st.sentCnt);
                default: next_st.rdata = '0; // Unmapped reads zero
            endcase
        end
        if (slotTick) begin
            case (st.phase)
                PH_RESET: begin
                    next_st.first = 1'b1;
                    // zero idle until the period ends
                    if (st.resetCnt == 16'(RESET_SLOTS_P - 1)) begin
                        next_st.bus = idleWord(CMD_NONZERO_IDLE);
                        next_st.phase = PH_IDLE;
                    end else begin
                        next_st.bus = idleWord(CMD_IDLE_ZERO);
                        next_st.resetCnt = st.resetCnt + 16'h0001;
                    end
                end
                PH_SEND: begin
                    next_st.bus = st.words[0];
                    next_st.words = {WORD_W'(0), st.words[2*BEATS-1:1]};
                    next_st.left = st.left - 4'h1;
                    // Second packet starts with no gap
                    next_st.first = (st.left == 4'(BEATS));
                    if (st.left == 4'h1) begin
                        next_st.phase = PH_IDLE;
                    end
                end
                PH_IDLE: begin
                    next_st.first = 1'b1;
                    next_st.bus = idleWord(CMD_NONZERO_IDLE);
                    if ((probeValid && !probeReply.missed) || (!probeValid
                            && (st.flushPend || (cmdValid && mapSend)))) begin
                        next_st.bus = pkt[0];
                        next_st.words = {WORD_W'(0), pkt[2*BEATS-1:1]};
                        next_st.left = (!probeValid && !st.flushPend && mapFollow)
                            ? 4'(2 * BEATS - 1) : 4'(BEATS - 1);
                        next_st.phase = PH_SEND;
                        next_st.sentCnt = st.sentCnt + 16'h0001;
                    end
                    if (!probeValid) begin
                        next_st.flushPend = 1'b0;
                    end
                end
                default: next_st.phase = PH_RESET;
            endcase
        end
        // A new match is never lost to the clear
        if (flushReq) begin
            next_st.flushPend = 1'b1;
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
            st.ctrl <= CTRL_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign outboundCmdBus = st.bus;
    assign regRdata = st.rdata;

    // Checks on the framer
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Start of a packet carrying a given code
    sequence s_start(logic [4:0] c);
        st.first && st.bus[13:9] == c;
    endsequence

    // Probe accepted with a hit
    sequence s_probe_take;
        idleSlot && probeValid && !probeReply.missed;
    endsequence

    a_idle_zero_reset: assert property (
        (st.phase == PH_RESET && st.first) |-> st.bus == '0)
        else $error("non-zero word during reset period");

    a_no_zero_idle: assert property (
        (st.phase != PH_RESET && st.first) |-> st.bus[13:9] != CMD_IDLE_ZERO)
        else $error("zero idle after reset period");

    a_probe_reply: assert property (
        s_probe_take |=> s_start(CMD_PROBE_REPLY) ##0 st.left == 4'(BEATS - 1))
        else $error("probe reply not started");

    a_probe_missed: assert property (
        (idleSlot && probeValid && probeReply.missed)
        |=> s_start(CMD_NONZERO_IDLE) ##0 st.phase == PH_IDLE)
        else $error("missed probe produced a packet");

    a_flush_sent: assert property (
        (idleSlot && !probeValid && st.flushPend) |=> s_start(CMD_FLUSH_REQ))
        else $error("flush request not sent");

    a_barrier_gate: assert property (
        s_start(CMD_BARRIER) |-> st.ctrl.barrierNoticeEn)
        else $error("barrier notice while disabled");

    a_discard_gate: assert property (
        s_start(CMD_DISCARD) |-> st.ctrl.discardEn)
        else $error("discard while disabled");

    a_four_beats: assert property (
        (st.first && st.phase == PH_SEND)
        |-> (st.left == 4'(BEATS - 1) || st.left == 4'(2 * BEATS - 1)))
        else $error("packet length wrong");

    a_pair_follow: assert property (
        (st.first && st.left == 4'(2 * BEATS - 1))
        |-> (st.words[BEATS-1][13:9] == CMD_VICTIM_WB
            || st.words[BEATS-1][13:9] == CMD_CLEAN_NOTICE))
        else $error("victim packet missing behind pair");

    a_rv_early: assert property (
        (st.first && st.bus[13:11] == CMD_EARLY_READ[4:2]
            && st.ctrl.pairedVictimMode) |-> !st.words[BEATS-2][14])
        else $error("request valid set in paired mode");

    a_legal_code: assert property (
        st.first |-> knownCode(st.bus[13:9]))
        else $error("unlisted command code");

    // Field and gate checks
    a_word_hold: assert property (
        !slotTick |=> $stable(outboundCmdBus))
        else $error("word moved mid slot");

    a_reply_status: assert property (
        s_probe_take |=> st.bus[8:7] == $past(probeReply.status))
        else $error("probe status not carried");

    a_reply_entry: assert property (
        s_probe_take |=> st.bus[4:2] == $past(probeReply.victimEntry))
        else $error("victim entry not carried");

    a_cond_upg_gate: assert property (
        s_start(CMD_COND_UPG) |-> st.ctrl.condStoreCmdEn)
        else $error("conditional upgrade while disabled");

    a_inv_upg_gate: assert property (
        s_start(CMD_INV_UPG) |-> &st.ctrl.invalidUpgradeCtrl)
        else $error("invalid upgrade not selected");

    a_early_gate: assert property (
        (st.first && st.bus[13:11] == CMD_EARLY_READ[4:2]) |-> st.ctrl.earlyReadEn)
        else $error("early read while disabled");

    a_paired_gate: assert property (
        (st.first && st.bus[13:11] == CMD_READ_VIC[4:2]) |-> st.ctrl.pairedVictimMode)
        else $error("paired read outside paired mode");

    a_flush_latch: assert property (
        flushReq |=> st.flushPend)
        else $error("flush match lost");

    a_missed_count: assert property (
        (idleSlot && probeValid && probeReply.missed) |=> $stable(st.sentCnt))
        else $error("missed probe counted as sent");

endmodule : outbound_system_command_encoder

// ### test/chipset_model.sv
// Far-side sampler: hands one outbound bus word per forwarded clock.
// Assumes each word is stable when the forwarded clock falls mid-slot.
`timescale 1ns/1ps
module chipset_model (
    input wire logic ref_clk,
    input wire logic linkClk,
    input wire logic [14:0] bus,
    output logic wordStrobe,
    output logic [14:0] word
);
    logic linkPrev; // Last sampled link level
    // Sample on the falling link edge, far from the word change
    always_ff @(posedge ref_clk) begin
        linkPrev <= linkClk;
        wordStrobe <= linkPrev && !linkClk;
        word <= bus;
    end
endmodule : chipset_model

// ### test/outbound_system_command_encoder_tb.sv
// Bench for the outbound command encoder with a sampling far side.
// Assumes shortened counts: four core cycles a slot, three reset slots.
`timescale 1ns/1ps
module outbound_system_command_encoder_tb
    import obc_pkg::*;
;
    localparam logic [14:0] IDLE = {1'b0, CMD_NONZERO_IDLE, 9'h000};
    typedef struct packed {logic [14:0] w; logic [14:0] care;} note_s;
    logic ref_clk = 0, rst = 1, regWr = 0, regRd = 0, cmdValid = 0, probeValid = 0, flushReq = 0;
    logic [7:0] regAddr = '0;
    logic [31:0] regWdata = '0;
    logic [31:0] regRdata;
    cmd_req_s cmdReq = '0;
    probe_rep_s probeReply = '0;
    logic cmdReady, probeReady, linkClk, wordStrobe, seenIdle = 0;
    logic [14:0] bus, word;
    int failures = 0, total_checks = 0, cycles = 0, seed = 32'h54d2;
    note_s q[$]; // Expected words, oldest first

    outbound_system_command_encoder #(.RESET_SLOTS_P(3), .DIV_P(4)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cmdValid(cmdValid),
        .cmdReq(cmdReq), .cmdReady(cmdReady), .probeValid(probeValid),
        .probeReply(probeReply), .probeReady(probeReady), .flushReq(flushReq),
        .outboundCmdBus(bus), .linkClkOut(linkClk));
    chipset_model u_far (.ref_clk(ref_clk), .linkClk(linkClk), .bus(bus),
        .wordStrobe(wordStrobe), .word(word));

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] care);
        total_checks++;
        if ((got & care) !== (exp & care)) begin
            failures++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 check(regRdata, exp, '1);
    endtask : rd

    // Four words of one packet, fields as sent on the bus
    task automatic push_cmd(input logic [4:0] c, input cmd_req_s r, input logic rv);
        q.push_back('{{1'b0, c, r.addr[39:31]}, 15'h7fff});
        q.push_back('{r.addr[30:16], 15'h7fff});
        q.push_back('{{1'b0, r.mask, 1'b0, r.id, r.addr[15:14]}, 15'h7fff});
        q.push_back('{{rv, r.addr[13:0]}, 15'h7fff});
    endtask : push_cmd

    // Code zero means the command must leave only idle words
    task automatic send(input op_e op, input logic [1:0] v, input logic hit, input logic cs,
                        input logic [4:0] c, input logic rv, input logic [4:0] fc);
        cmd_req_s r;
        logic io;
        io = op == OP_IO_READ || op == OP_IO_WRITE;
        r = {op, v, cs, hit, fc != 0, fc != 0, fc == 5'h04, 3'($random(seed)), 3'($random(seed)),
             io ? 8'($random(seed)) : 8'h00, 40'({$random(seed), $random(seed)}),
             40'({$random(seed), $random(seed)})};
        r.addr |= 40'h0040006000; // No word may alias the idle word
        r.vicAddr |= 40'h0040006000;
        @(posedge ref_clk);
        cmdValid <= 1'b1;
        cmdReq <= r;
        do @(posedge ref_clk); while (cmdReady !== 1'b1);
        cmdValid <= 1'b0;
        if (c != 0) push_cmd(c, r, rv);
        if (fc != 0) push_cmd(fc, '{op: op, id: r.vicId, addr: r.vicAddr, default: '0}, 1'b1);
    endtask : send

    task automatic probe(input logic miss, input logic [1:0] s);
        probe_rep_s p;
        p = {miss, s, 9'($random(seed))};
        @(posedge ref_clk);
        probeValid <= 1'b1;
        probeReply <= p;
        do @(posedge ref_clk); while (probeReady !== 1'b1);
        probeValid <= 1'b0;
        if (miss) return;
        q.push_back('{{1'b0, 5'h01, p.status, p.moveData, p.victimSent, p.victimEntry, 2'b0},
                      15'h7ffc});
        q.push_back('{{9'h0, p.missSent, p.missEntry, 2'b0}, 15'h7ffc});
        q.push_back('{15'h0, 15'h0});
        q.push_back('{15'h0, 15'h0});
    endtask : probe

    // Watcher: idle words skipped, others matched oldest first
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
        if (wordStrobe === 1'b1 && word === IDLE) begin
            seenIdle <= 1'b1;
        end else if (wordStrobe === 1'b1 && q.size() != 0) begin
            check(word, q[0].w, q[0].care);
            void'(q.pop_front());
        end else if (wordStrobe === 1'b1) begin
            check(word, seenIdle ? IDLE : 15'h0, '1);
        end
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        wr(REG_CTRL, 32'h4ff);
        rd(REG_CTRL, 32'h4ff);
        rd(8'h0c, 32'h0);
        for (int v = 0; v < 4; v++) send(OP_READ, 2'(v), 0, 0, 5'h10 + 5'(v), 1, 0);
        for (int g = 0; g < 3; g++) begin
            send(OP_IO_READ, 2'(g), 0, 0, 5'h08 + 5'(g), 1, 0);
            send(OP_IO_WRITE, 2'(g), 0, 0, 5'h0c + 5'(g), 1, 0);
            send(OP_UPGRADE, 2'(g), 0, 0, g == 0 ? 5'h1c : 5'h1d, 1, 0);
        end
        send(OP_UPGRADE, 2'd1, 0, 1, 5'h1e, 1, 0);
        send(OP_WRITE_HINT, 0, 0, 0, 5'h1f, 1, 0);
        send(OP_BARRIER, 0, 0, 0, 5'h07, 1, 0);
        send(OP_DISCARD, 0, 0, 0, 5'h06, 1, 0);
        send(OP_VICTIM_WB, 0, 0, 0, 5'h04, 1, 0);
        send(OP_CLEAN_NOTICE, 0, 0, 0, 5'h05, 1, 0);
        for (int s = 0; s < 4; s++) probe(0, 2'(s));
        probe(1, 2'd0);
        @(posedge ref_clk);
        flushReq <= 1'b1;
        q.push_back('{{1'b0, 5'h03, 9'h0}, 15'h7fff});
        repeat (3) q.push_back('{15'h0, 15'h0});
        @(posedge ref_clk);
        flushReq <= 1'b0;
        wr(REG_CTRL, 32'h6ff);
        for (int v = 0; v < 4; v++) send(OP_READ, 2'(v), v[0], 0, 5'h14 + 5'(v), !v[0], 0);
        wr(REG_CTRL, 32'h5ff);
        for (int v = 0; v < 3; v++) send(OP_READ, 2'(v), 0, 0, 5'h18 + 5'(v), 1, v == 1 ? 5'h05 : 5'h04);
        send(OP_DISCARD, 0, 0, 0, 5'h06, 1, 5'h04);
        wr(REG_CTRL, 32'h010);
        send(OP_BARRIER, 0, 0, 0, 5'h00, 1, 0);
        send(OP_WRITE_HINT, 0, 0, 0, 5'h00, 1, 0);
        repeat (100) @(posedge ref_clk);
        rd(REG_SENT, 32'h20);
        rd(REG_STATUS, 32'h1);
        check(q.size(), 0, '1);
        end_of_test();
    end
endmodule : outbound_system_command_encoder_tb
